// File: rtl/osc_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing for the oscillator control block
package osc_ctrl_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] LF_CTRL_IDX    = 8'h86;
    localparam logic [7:0] HF_CTRL_IDX    = 8'hb2;
    localparam logic [7:0] MULT_IDX       = 8'hb9;
    localparam logic [7:0] IRQ_STAT_IDX   = 8'hc0;
    localparam logic [7:0] IRQ_EN_IDX     = 8'hc1;
    localparam logic [7:0] IRQ_CLR_IDX    = 8'hc2;
    localparam logic [7:0] CAPT_CTRL_IDX  = 8'hc3;
    localparam logic [7:0] CAPT_FALL_IDX  = 8'hc4;
    localparam logic [7:0] CAPT_RISE_IDX  = 8'hc5;
    localparam logic [7:0] LF_TRIM_IDX    = 8'hc6;

    // Field positions
    localparam int HF_ON_BIT      = 7;
    localparam int HF_OK_BIT      = 6;
    localparam int HF_SUSP_BIT    = 5;
    localparam int LF_ON_BIT      = 7;
    localparam int LF_OK_BIT      = 6;
    localparam int LF_TUNE_LSB    = 2;
    localparam int IRQ_HF_OK      = 0;
    localparam int IRQ_LF_OK      = 1;
    localparam int IRQ_WAKE       = 2;
    localparam int IRQ_CAPT_FALL  = 3;
    localparam int IRQ_CAPT_RISE  = 4;
    localparam int IRQ_W          = 5;

    // Reset values
    localparam logic [7:0] HF_CTRL_RST   = 8'hc0;
    localparam logic [7:0] MULT_VALUE    = 8'he0;
    localparam logic [1:0] HF_DIV_RST    = 2'h0;
    localparam logic [1:0] LF_DIV_RST    = 2'h0;
    localparam logic [3:0] LF_TUNE_RST   = 4'h8;

    // Timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int HF_SETTLE_NS   = 2000;
    localparam int LF_SETTLE_NS   = 100000;
    localparam int HF_SETTLE_CYC  = (HF_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int LF_SETTLE_CYC  = (LF_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int LF_TICK_CYC    = 125;
endpackage : osc_ctrl_pkg

// File: rtl/osc_divider.sv
// Power-of-two enable divider: code 00 divides by 8, 11 by 1
module osc_divider (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Control
    input  wire logic       i_run,
    input  wire logic       i_tick,
    input  wire logic [1:0] i_code,
    // Output
    output logic            o_tick
);
    logic [2:0] cnt_q;
    logic [2:0] mask;

    always_comb begin
        unique case (i_code)
            2'h0: mask = 3'h7;
            2'h1: mask = 3'h3;
            2'h2: mask = 3'h1;
            2'h3: mask = 3'h0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 3'h0;
        end else if (!i_run) begin
            cnt_q <= 3'h0;
        end else if (i_tick) begin
            cnt_q <= ((cnt_q & mask) == mask) ? 3'h0 : cnt_q + 3'h1;
        end
    end

    assign o_tick = i_run && i_tick && ((cnt_q & mask) == mask);
endmodule : osc_divider

// File: rtl/osc_ctrl.sv
// Internal oscillator control registers, suspend, dividers and low-frequency capture
//
// The Wishbone register port was chosen for this implementation.
module osc_ctrl #(
    parameter int HF_SETTLE = osc_ctrl_pkg::HF_SETTLE_CYC,
    parameter int LF_SETTLE = osc_ctrl_pkg::LF_SETTLE_CYC,
    parameter int LF_TICK   = osc_ctrl_pkg::LF_TICK_CYC
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Wake sources
    input  wire logic        i_usb_active,
    input  wire logic        i_vbus_sense,
    // Timer counts to capture
    input  wire logic [15:0] i_timer2_count,
    input  wire logic [15:0] i_timer3_count,
    // Oscillator status and clock enables
    output logic             o_hf_running,
    output logic             o_hf_sys_tick,
    output logic             o_lf_running,
    output logic             o_lf_level,
    output logic             o_lf_sys_tick,
    output logic             o_irq
);
    localparam int HCW = $clog2(HF_SETTLE + 1);
    localparam int LCW = $clog2(LF_SETTLE + 1);
    localparam int TCW = $clog2(LF_TICK + 16);
    localparam int IRQ_W_L = osc_ctrl_pkg::IRQ_W;

    typedef enum logic [1:0] {
        HF_OFF    = 2'b00,
        HF_SETTLE_ST = 2'b01,
        HF_RUN    = 2'b11,
        HF_SUSP   = 2'b10
    } hf_state_type;

    hf_state_type     hf_state_q;
    logic             hf_osc_on_q;
    logic [1:0]       hf_post_divider_q;
    logic [HCW-1:0]   hf_cnt_q;
    logic             lf_osc_on_q;
    logic             lf_freq_ok_q;
    logic [3:0]       lf_fine_tune_q;
    logic [1:0]       lf_divider_q;
    logic [LCW-1:0]   lf_cnt_q;
    logic [TCW-1:0]   lf_ph_q;
    logic             lf_level_q;
    logic [1:0]       capt_mode_q;
    logic [15:0]      reload2_q;
    logic [15:0]      reload3_q;
    logic [IRQ_W_L-1:0] irq_stat_q;
    logic [IRQ_W_L-1:0] irq_en_q;
    logic             vbus_q;
    logic             ack_q;
    logic [31:0]      rdat_q;
    logic             hf_ok_q;
    logic [1:0]       hf_quarter_q;

    logic             req;
    logic             wr;
    logic [7:0]       idx;
    logic [7:0]       wdat;
    logic             wake;
    logic             lf_edge_rise;
    logic             lf_edge_fall;
    logic             hf_quarter_tick;
    logic [IRQ_W_L-1:0] irq_set;
    logic [7:0]       rd_mux;
    logic             hf_settle_done;
    logic             lf_settle_done;
    logic             lf_half_done;
    logic             wr_hf_ctrl;
    logic             wr_lf_ctrl;
    logic             wr_capt_ctrl;
    logic             wr_irq_clr;
    logic             wr_irq_en;

    assign req  = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr   = req && i_wb_we && i_wb_sel[0];
    assign idx  = i_wb_adr[9:2];
    assign wdat = i_wb_dat[7:0];
    assign wake = i_usb_active || (i_vbus_sense != vbus_q);

    // Write strobes and event decodes
    assign wr_hf_ctrl     = wr && (idx == osc_ctrl_pkg::HF_CTRL_IDX);
    assign wr_lf_ctrl     = wr && (idx == osc_ctrl_pkg::LF_CTRL_IDX);
    assign wr_capt_ctrl   = wr && (idx == osc_ctrl_pkg::CAPT_CTRL_IDX);
    assign wr_irq_clr     = wr && (idx == osc_ctrl_pkg::IRQ_CLR_IDX);
    assign wr_irq_en      = wr && (idx == osc_ctrl_pkg::IRQ_EN_IDX);
    assign hf_settle_done = (hf_state_q == HF_SETTLE_ST) && hf_osc_on_q && (hf_cnt_q == HCW'(HF_SETTLE - 1));
    assign lf_settle_done = lf_osc_on_q && !lf_freq_ok_q && (lf_cnt_q == LCW'(LF_SETTLE - 1));
    assign lf_half_done   = lf_ph_q >= TCW'(LF_TICK - 1) + TCW'(lf_fine_tune_q);

    // Bus-power edge detect
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vbus_q <= 1'b0;
        end else begin
            vbus_q <= i_vbus_sense;
        end
    end

    // HF control fields; suspend bit is a command, not stored
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hf_osc_on_q       <= osc_ctrl_pkg::HF_CTRL_RST[osc_ctrl_pkg::HF_ON_BIT];
            hf_post_divider_q <= osc_ctrl_pkg::HF_DIV_RST;
        end else if (wr_hf_ctrl) begin
            hf_osc_on_q       <= wdat[osc_ctrl_pkg::HF_ON_BIT];
            hf_post_divider_q <= wdat[1:0];
        end
    end

    // HF oscillator state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hf_state_q <= HF_RUN;
            hf_cnt_q   <= '0;
        end else begin
            unique case (hf_state_q)
                HF_OFF: begin
                    if (hf_osc_on_q) begin
                        hf_state_q <= HF_SETTLE_ST;
                        hf_cnt_q   <= '0;
                    end
                end
                HF_SETTLE_ST: begin
                    if (!hf_osc_on_q) begin
                        hf_state_q <= HF_OFF;
                    end else if (hf_settle_done) begin
                        hf_state_q <= HF_RUN;
                    end else begin
                        hf_cnt_q <= hf_cnt_q + 1'b1;
                    end
                end
                HF_RUN: begin
                    if (!hf_osc_on_q) begin
                        hf_state_q <= HF_OFF;
                    end else if (wr_hf_ctrl && wdat[osc_ctrl_pkg::HF_SUSP_BIT]) begin
                        hf_state_q <= HF_SUSP;
                    end
                end
                HF_SUSP: begin
                    if (wake) begin
                        hf_state_q <= HF_RUN;
                    end
                end
            endcase
        end
    end

    always_comb hf_ok_q = (hf_state_q == HF_RUN);
    assign o_hf_running = hf_ok_q;

    // Divide-by-4 stage of the 48 MHz core, modelled as system-clock ticks
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hf_quarter_q <= 2'h0;
        end else if (hf_ok_q) begin
            hf_quarter_q <= hf_quarter_q + 2'h1;
        end
    end
    assign hf_quarter_tick = hf_ok_q && (hf_quarter_q == 2'h3);

    osc_divider u_hf_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (hf_ok_q),
        .i_tick    (hf_quarter_tick),
        .i_code    (hf_post_divider_q),
        .o_tick    (o_hf_sys_tick)
    );

    // LF control fields
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lf_osc_on_q    <= 1'b0;
            lf_fine_tune_q <= osc_ctrl_pkg::LF_TUNE_RST;
            lf_divider_q   <= osc_ctrl_pkg::LF_DIV_RST;
        end else if (wr_lf_ctrl) begin
            lf_osc_on_q    <= wdat[osc_ctrl_pkg::LF_ON_BIT];
            lf_fine_tune_q <= wdat[osc_ctrl_pkg::LF_TUNE_LSB +: 4];
            lf_divider_q   <= wdat[1:0];
        end
    end

    // LF ready: sticky until reset or divider change
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lf_freq_ok_q <= 1'b0;
            lf_cnt_q     <= '0;
        end else if (wr_lf_ctrl && wdat[1:0] != lf_divider_q) begin
            lf_freq_ok_q <= 1'b0;
            lf_cnt_q     <= '0;
        end else if (lf_osc_on_q && !lf_freq_ok_q) begin
            if (lf_settle_done) begin
                lf_freq_ok_q <= 1'b1;
            end else begin
                lf_cnt_q <= lf_cnt_q + 1'b1;
            end
        end
    end
    assign o_lf_running = lf_osc_on_q;

    // LF output: half period stretched by fine-tune
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lf_ph_q    <= '0;
            lf_level_q <= 1'b0;
        end else if (!lf_osc_on_q) begin
            lf_ph_q    <= '0;
        end else if (lf_half_done) begin
            lf_ph_q    <= '0;
            lf_level_q <= !lf_level_q;
        end else begin
            lf_ph_q <= lf_ph_q + 1'b1;
        end
    end
    assign o_lf_level   = lf_level_q;
    assign lf_edge_rise = lf_osc_on_q && !lf_level_q && lf_half_done;
    assign lf_edge_fall = lf_osc_on_q && lf_level_q && lf_half_done;

    osc_divider u_lf_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (lf_osc_on_q),
        .i_tick    (lf_edge_rise),
        .i_code    (lf_divider_q),
        .o_tick    (o_lf_sys_tick)
    );

    // Capture mode control
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            capt_mode_q <= 2'h0;
        end else if (wr_capt_ctrl) begin
            capt_mode_q <= wdat[1:0];
        end
    end

    // Edge captures into reload registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            reload2_q <= 16'h0000;
            reload3_q <= 16'h0000;
        end else begin
            if (capt_mode_q[0] && lf_edge_fall) begin
                reload2_q <= i_timer2_count;
            end
            if (capt_mode_q[1] && lf_edge_rise) begin
                reload3_q <= i_timer3_count;
            end
        end
    end

    // Interrupt status, set wins over clear
    always_comb begin
        irq_set                           = '0;
        irq_set[osc_ctrl_pkg::IRQ_HF_OK]     = hf_settle_done;
        irq_set[osc_ctrl_pkg::IRQ_LF_OK]     = lf_settle_done;
        irq_set[osc_ctrl_pkg::IRQ_WAKE]      = (hf_state_q == HF_SUSP) && wake;
        irq_set[osc_ctrl_pkg::IRQ_CAPT_FALL] = capt_mode_q[0] && lf_edge_fall;
        irq_set[osc_ctrl_pkg::IRQ_CAPT_RISE] = capt_mode_q[1] && lf_edge_rise;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_stat_q <= '0;
        end else if (wr_irq_clr) begin
            irq_stat_q <= (irq_stat_q & ~wdat[IRQ_W_L-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_en_q <= '0;
        end else if (wr_irq_en) begin
            irq_en_q <= wdat[IRQ_W_L-1:0];
        end
    end
    assign o_irq = |(irq_stat_q & irq_en_q);

    // Read mux
    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            osc_ctrl_pkg::HF_CTRL_IDX:  rd_mux = {hf_osc_on_q, hf_ok_q, 1'b0, 3'h0, hf_post_divider_q};
            osc_ctrl_pkg::MULT_IDX:     rd_mux = osc_ctrl_pkg::MULT_VALUE;
            osc_ctrl_pkg::LF_CTRL_IDX:  rd_mux = {lf_osc_on_q, lf_freq_ok_q, lf_fine_tune_q, lf_divider_q};
            osc_ctrl_pkg::IRQ_STAT_IDX: rd_mux = {3'h0, irq_stat_q};
            osc_ctrl_pkg::IRQ_EN_IDX:   rd_mux = {3'h0, irq_en_q};
            osc_ctrl_pkg::CAPT_CTRL_IDX: rd_mux = {6'h00, capt_mode_q};
            osc_ctrl_pkg::CAPT_FALL_IDX: rd_mux = reload2_q[15:8];
            osc_ctrl_pkg::CAPT_RISE_IDX: rd_mux = reload3_q[15:8];
            osc_ctrl_pkg::LF_TRIM_IDX:   rd_mux = {reload2_q[7:0]};
            default:                     rd_mux = 8'h00;
        endcase
    end

    // Bus answer: ack one cycle after request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req;
            if (req && !i_wb_we) begin
                rdat_q <= {24'h00_0000, rd_mux};
            end
        end
    end
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
endmodule : osc_ctrl

// File: sim/osc_ctrl_monitor.sv
// Port checker for the oscillator control block
module osc_ctrl_monitor (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // Bus
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [9:0]  i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // Oscillators
    input wire logic        o_hf_running,
    input wire logic        o_hf_sys_tick,
    input wire logic        o_lf_running,
    input wire logic        o_lf_sys_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic req;
    logic rd;
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign rd  = req && !i_wb_we;
    property p_ack_next; req |=> o_wb_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_idle; !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_mult; rd && i_wb_adr[9:2] == osc_ctrl_pkg::MULT_IDX |=> o_wb_dat == 32'h0000_00e0; endproperty
    a_mult: assert property (p_mult) else $error("multiplier read wrong");
    property p_hf_zero; rd && i_wb_adr[9:2] == osc_ctrl_pkg::HF_CTRL_IDX |=> o_wb_dat[5:2] == 4'h0; endproperty
    a_hf_zero: assert property (p_hf_zero) else $error("hf unused bits set");
    property p_unmapped; rd && i_wb_adr[9:2] < osc_ctrl_pkg::LF_CTRL_IDX |=> o_wb_dat == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hf_stop; !o_hf_running [*3] |-> !o_hf_sys_tick; endproperty
    a_hf_stop: assert property (p_hf_stop) else $error("hf tick while stopped");
    property p_lf_stop; !o_lf_running [*3] |-> !o_lf_sys_tick; endproperty
    a_lf_stop: assert property (p_lf_stop) else $error("lf tick while stopped");
endmodule : osc_ctrl_monitor

bind osc_ctrl osc_ctrl_monitor osc_ctrl_monitor_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_hf_running(o_hf_running), .o_hf_sys_tick(o_hf_sys_tick),
    .o_lf_running(o_lf_running), .o_lf_sys_tick(o_lf_sys_tick)
);

// File: sim/testbench.sv
// Self-checking bench for the oscillator control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_wb_cyc = 1'b0;
    logic        i_wb_stb = 1'b0;
    logic        i_wb_we = 1'b0;
    logic [9:0]  i_wb_adr = 10'h0;
    logic [3:0]  i_wb_sel = 4'h1;
    logic [31:0] i_wb_dat = 32'h0;
    logic        i_usb_active = 1'b0;
    logic        i_vbus_sense = 1'b0;
    logic [15:0] i_timer2_count = 16'h1234;
    logic [15:0] i_timer3_count = 16'h5678;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack, o_hf_running, o_hf_sys_tick, o_lf_running, o_lf_level, o_lf_sys_tick, o_irq;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cnt [4];
    int          n_edges;
    logic        lvl;
    always #25 i_clk = ~i_clk;
    osc_ctrl #(.HF_SETTLE(8), .LF_SETTLE(10), .LF_TICK(4)) osc_ctrl_i (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_usb_active(i_usb_active),
        .i_vbus_sense(i_vbus_sense), .i_timer2_count(i_timer2_count), .i_timer3_count(i_timer3_count),
        .o_hf_running(o_hf_running), .o_hf_sys_tick(o_hf_sys_tick), .o_lf_running(o_lf_running),
        .o_lf_level(o_lf_level), .o_lf_sys_tick(o_lf_sys_tick), .o_irq(o_irq)
    );
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One classic cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int k;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= {idx, 2'b00};
        i_wb_dat <= {24'h0, wd};
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (o_wb_ack === 1'b1) break;
        end
        rd = o_wb_dat[7:0];
        check("ack", 8'h1, {7'h0, k < 20});
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] v;
        wb(1'b1, idx, wd, v);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string name);
        logic [7:0] v;
        wb(1'b0, idx, 8'h0, v);
        check(name, exp, v);
    endtask : rdc
    task automatic count(input logic lf, output int n);
        n = 0;
        repeat (512) begin
            @(posedge i_clk);
            n += lf ? int'(o_lf_sys_tick === 1'b1) : int'(o_hf_sys_tick === 1'b1);
        end
    endtask : count
    task automatic wait_hf;
        for (int k = 0; k < 200 && o_hf_running !== 1'b1; k++) @(posedge i_clk);
    endtask : wait_hf
    task automatic wait_lf;
        logic [7:0] v;
        for (int k = 0; k < 60; k++) begin
            wb(1'b0, osc_ctrl_pkg::LF_CTRL_IDX, 8'h0, v);
            if (v[6] === 1'b1) break;
        end
    endtask : wait_lf
    initial begin
        #2ms;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'hc0, "hf reset");
        rdc(osc_ctrl_pkg::MULT_IDX, 8'he0, "mult reset");
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'h20, "lf reset");
        rdc(8'h10, 8'h00, "unmapped");
        wr(osc_ctrl_pkg::MULT_IDX, 8'h1f);
        rdc(osc_ctrl_pkg::MULT_IDX, 8'he0, "mult written");
        wr(osc_ctrl_pkg::HF_CTRL_IDX, 8'h5c);
        rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'h00, "hf off");
        wr(osc_ctrl_pkg::HF_CTRL_IDX, 8'h80);
        wait_hf();
        rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'hc0, "hf on");
        i_wb_sel <= 4'h0;
        wr(osc_ctrl_pkg::HF_CTRL_IDX, 8'h00);
        i_wb_sel <= 4'h1;
        rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'hc0, "sel ignored");
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            wr(osc_ctrl_pkg::HF_CTRL_IDX, 8'h80 | 8'(c));
            count(1'b0, cnt[c]);
        end
        check("hf ticks", 8'h1, {7'h0, cnt[0] >= 15 && cnt[0] <= 17});
        check("hf full", 8'h1, {7'h0, cnt[3] >= 127 && cnt[3] <= 129});
        for (int c = 1; c < 4; c++) begin
            check("hf ratio", 8'h1, {7'h0, cnt[c] >= 2 * cnt[c-1] - 2 && cnt[c] <= 2 * cnt[c-1] + 2});
        end
        $display("test hf divider done");
        for (int s = 0; s < 3; s++) begin
            wr(osc_ctrl_pkg::HF_CTRL_IDX, 8'ha0);
            repeat (20) @(posedge i_clk);
            check("suspended", 8'h0, {7'h0, o_hf_running});
            rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'h80, "hf suspended");
            if (s == 1) i_usb_active <= 1'b1;
            else i_vbus_sense <= ~i_vbus_sense;
            wait_hf();
            i_usb_active <= 1'b0;
            check("woken", 8'h1, {7'h0, o_hf_running});
        end
        $display("test suspend done");
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'h03);
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'h83);
        wait_lf();
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'hc3, "lf ready");
        check("lf running", 8'h1, {7'h0, o_lf_running});
        count(1'b1, cnt[3]);
        lvl = o_lf_level;
        repeat (4) @(posedge i_clk);
        check("lf level", {7'h0, ~lvl}, {7'h0, o_lf_level});
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'h80);
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'h80, "lf div change");
        wait_lf();
        count(1'b1, cnt[0]);
        check("lf ratio", 8'h1, {7'h0, cnt[0] > 0 && cnt[3] >= 6 * cnt[0] && cnt[3] <= 10 * cnt[0]});
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'h80);
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'hc0, "lf same div");
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'h00);
        wr(osc_ctrl_pkg::LF_CTRL_IDX, 8'hbc);
        n_edges = 0;
        lvl = o_lf_level;
        repeat (190) begin
            @(posedge i_clk);
            if (o_lf_level !== lvl) n_edges++;
            lvl = o_lf_level;
        end
        check("lf slowest", 8'h1, {7'h0, n_edges >= 9 && n_edges <= 11});
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'hfc, "lf tuned");
        $display("test lf done");
        rdc(osc_ctrl_pkg::IRQ_STAT_IDX, 8'h07, "events");
        wr(osc_ctrl_pkg::IRQ_CLR_IDX, 8'h1f);
        wr(osc_ctrl_pkg::IRQ_EN_IDX, 8'h18);
        wr(osc_ctrl_pkg::CAPT_CTRL_IDX, 8'h03);
        rdc(osc_ctrl_pkg::IRQ_EN_IDX, 8'h18, "irq enable");
        rdc(osc_ctrl_pkg::CAPT_CTRL_IDX, 8'h03, "capture mode");
        repeat (60) @(posedge i_clk);
        rdc(osc_ctrl_pkg::IRQ_STAT_IDX, 8'h18, "captures");
        check("irq on", 8'h1, {7'h0, o_irq});
        rdc(osc_ctrl_pkg::CAPT_FALL_IDX, 8'h12, "fall high");
        rdc(osc_ctrl_pkg::CAPT_RISE_IDX, 8'h56, "rise high");
        rdc(osc_ctrl_pkg::LF_TRIM_IDX, 8'h34, "fall low");
        wr(osc_ctrl_pkg::IRQ_EN_IDX, 8'h00);
        check("irq masked", 8'h0, {7'h0, o_irq});
        wr(osc_ctrl_pkg::IRQ_EN_IDX, 8'h18);
        wr(osc_ctrl_pkg::CAPT_CTRL_IDX, 8'h00);
        wr(osc_ctrl_pkg::IRQ_CLR_IDX, 8'h1f);
        rdc(osc_ctrl_pkg::IRQ_STAT_IDX, 8'h00, "cleared");
        check("irq off", 8'h0, {7'h0, o_irq});
        $display("test capture done");
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(osc_ctrl_pkg::LF_CTRL_IDX, 8'h20, "lf after reset");
        rdc(osc_ctrl_pkg::HF_CTRL_IDX, 8'hc0, "hf after reset");
        rdc(osc_ctrl_pkg::IRQ_STAT_IDX, 8'h00, "status after reset");
        $display("test reset done");
        finish_test();
    end
endmodule : testbench
